// *** hw/gsf_pkg.sv ***
// Register map, field positions and reset values of the pin/fault block
package gsf_pkg;
  localparam logic [7:0] GSF_OFS_PIN_CFG   = 8'h33;
  localparam logic [7:0] GSF_OFS_STATE     = 8'h40;
  localparam logic [7:0] GSF_OFS_FAULT     = 8'h41;
  localparam logic [7:0] GSF_OFS_PIN3_CTRL = 8'h42;
  // Field positions in the configuration register
  localparam int GSF_CFG_P1_LSB = 6;
  localparam int GSF_CFG_P2_LSB = 4;
  localparam int GSF_CFG_P3_LSB = 2;
  localparam int GSF_CFG_DRIVE2 = 1;
  // Third pin control bits
  localparam int GSF_CTL_ALERT  = 7;
  localparam int GSF_CTL_PULL3  = 6;
  // Fault / state bits
  localparam int GSF_BIT_P1     = 6;
  localparam int GSF_BIT_P2     = 5;
  localparam int GSF_BIT_P3     = 4;
  localparam int GSF_BIT_BUSY   = 3;
  localparam int GSF_BIT_WAKE   = 3;
  localparam int GSF_BIT_ENERGY = 2;
  localparam int GSF_BIT_CHARGE = 1;
  localparam int GSF_BIT_TIME   = 0;
  // Reset values
  localparam logic [7:0] GSF_RST_PIN_CFG   = 8'h00;
  localparam logic [7:0] GSF_RST_FAULT     = 8'h80;
  localparam logic [7:0] GSF_RST_PIN3_CTRL = 8'h00;
  // Pin mode codes
  typedef enum logic [1:0] {
    GSF_MODE_SPECIAL = 2'b00,
    GSF_MODE_OUT     = 2'b01,
    GSF_MODE_IN_LOW  = 2'b10,
    GSF_MODE_IN_HIGH = 2'b11
  } gsf_mode_t;
endpackage

// *** hw/gsf_pin_decode.sv ***
// One pin: mode decode into input-mode flag and active-level detect
`timescale 1ns/100ps
module gsf_pin_decode
  import gsf_pkg::*;
(
  // Mode and sampled level
  input  wire logic [1:0] mode_in,
  input  wire logic       level_in,
  // Decoded results
  output logic            is_input_out,
  output logic            active_out
);
  gsf_mode_t mode;
  assign mode         = gsf_mode_t'(mode_in);
  assign is_input_out = (mode == GSF_MODE_IN_LOW) ||
                        (mode == GSF_MODE_IN_HIGH);
  // Active level: high when active-high, low when active-low
  assign active_out   = is_input_out &&
                        (level_in == (mode == GSF_MODE_IN_HIGH));
endmodule

// *** hw/gsf_pins.sv ***
// Pin configuration, state, latched faults and alert output of three pins
`timescale 1ns/100ps
// How it works
// RQ1: First pin: inputs, Hi-Z, or pull low
// RQ2: Second pin: inputs, driven output, accumulate gating
// RQ3: Second pin output pulls low when bit set
// RQ4: Third pin: inputs, control register output, alert
// RQ5: First pin state reads active-level match
// RQ6: Second pin state: raw gating or active
// RQ7: Third pin state reads active-level match
// RQ8: Busy bit reflects snapshot conversion
// RQ9: Live overflow bits for three accumulators
// RQ10: Input pins latch fault when seen active
// RQ11: Wake fault set on stuck-bus wake exit
// RQ12: Overflow fault bits for three accumulators
// RQ13: Alert bit set by alert, cleared by 0
// RQ14: Alert mode pulls third pin low while alert bit set
// RQ15: Third pin output follows pull-down bit
// RQ16: Overflow alert only when enabled
// RQ17: Faults hold until host writes zero
module gsf_pins
  import gsf_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       clk_en_in,
  // Register access from the serial slave engine
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_hit_out,
  // Pin levels
  input  wire logic       first_pin_in,
  input  wire logic       second_pin_in,
  input  wire logic       third_pin_in,
  // Pin drives (enable low means pulling the pin low)
  output logic            first_pin_out,
  output logic            first_pin_oe_n_out,
  output logic            second_pin_out,
  output logic            second_pin_oe_n_out,
  output logic            third_pin_out,
  output logic            third_pin_oe_n_out,
  // Accumulate gating to the accumulators
  output logic            accumulate_gating_out,
  // Core status and events
  input  wire logic       adc_busy_in,
  input  wire logic       energy_ovf_in,
  input  wire logic       charge_ovf_in,
  input  wire logic       time_ovf_in,
  input  wire logic       wake_exit_in,
  input  wire logic       stuck_bus_wake_enable_in,
  input  wire logic [2:0] secondary_alert_enable_in,
  input  wire logic       other_alert_in
);
  logic [7:0] cfg_q;
  logic [7:0] fault_q;
  logic [7:0] fault_d;
  logic [1:0] ctl_q;
  logic [1:0] ctl_d;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] state_w;
  logic [7:0] fault_set;
  logic [2:0] act;
  logic [2:0] ovf_rise;
  logic [2:0] ovf_prev_q;
  logic       ovf_alert;
  logic       alert_event;
  logic       wr_cfg;
  logic       wr_fault;
  logic       wr_ctl;
  logic       acc_mode2;
  logic       out_mode2;
  logic       out_mode3;
  logic       alert_mode3;

  // Per-pin decode shares one module
  gsf_pin_decode u_dec1 (
    .mode_in      (cfg_q[GSF_CFG_P1_LSB +: 2]),
    .level_in     (first_pin_in),
    .is_input_out (),
    .active_out   (act[2])
  );
  gsf_pin_decode u_dec2 (
    .mode_in      (cfg_q[GSF_CFG_P2_LSB +: 2]),
    .level_in     (second_pin_in),
    .is_input_out (),
    .active_out   (act[1])
  );
  gsf_pin_decode u_dec3 (
    .mode_in      (cfg_q[GSF_CFG_P3_LSB +: 2]),
    .level_in     (third_pin_in),
    .is_input_out (),
    .active_out   (act[0])
  );

  // Address decode
  assign wr_cfg   = reg_wr_in && (reg_addr_in == GSF_OFS_PIN_CFG);
  assign wr_fault = reg_wr_in && (reg_addr_in == GSF_OFS_FAULT);
  assign wr_ctl   = reg_wr_in && (reg_addr_in == GSF_OFS_PIN3_CTRL);
  assign reg_hit_out = (reg_addr_in == GSF_OFS_PIN_CFG) ||
                       (reg_addr_in == GSF_OFS_STATE) ||
                       (reg_addr_in == GSF_OFS_FAULT) ||
                       (reg_addr_in == GSF_OFS_PIN3_CTRL);

  // Mode decode of second and third pins
  assign acc_mode2   = cfg_q[GSF_CFG_P2_LSB +: 2] == GSF_MODE_SPECIAL; // RQ2
  assign out_mode2   = cfg_q[GSF_CFG_P2_LSB +: 2] == GSF_MODE_OUT;     // RQ2
  assign out_mode3   = cfg_q[GSF_CFG_P3_LSB +: 2] == GSF_MODE_OUT;     // RQ4
  assign alert_mode3 = cfg_q[GSF_CFG_P3_LSB +: 2] == GSF_MODE_SPECIAL; // RQ4

  // Pin drives: output value fixed low, only the enable moves
  assign first_pin_out  = 1'b0;
  assign second_pin_out = 1'b0;
  assign third_pin_out  = 1'b0;
  assign first_pin_oe_n_out =
    !(cfg_q[GSF_CFG_P1_LSB +: 2] == GSF_MODE_SPECIAL); // RQ1
  assign second_pin_oe_n_out =
    !(out_mode2 && cfg_q[GSF_CFG_DRIVE2]); // RQ3
  assign third_pin_oe_n_out =
    !((out_mode3 && ctl_q[0]) ||                        // RQ15
      (alert_mode3 && ctl_q[1]));                       // RQ14
  assign accumulate_gating_out = acc_mode2 && second_pin_in; // RQ2

  // Live state register
  assign state_w[7]              = 1'b0;
  assign state_w[GSF_BIT_P1]     = act[2];                   // RQ5
  assign state_w[GSF_BIT_P2]     = acc_mode2 ? second_pin_in
                                             : act[1];       // RQ6
  assign state_w[GSF_BIT_P3]     = act[0];                   // RQ7
  assign state_w[GSF_BIT_BUSY]   = adc_busy_in;              // RQ8
  assign state_w[GSF_BIT_ENERGY] = energy_ovf_in;            // RQ9
  assign state_w[GSF_BIT_CHARGE] = charge_ovf_in;            // RQ9
  assign state_w[GSF_BIT_TIME]   = time_ovf_in;              // RQ9

  // Overflow events are rising edges of the live overflow levels
  assign ovf_rise = {energy_ovf_in, charge_ovf_in, time_ovf_in} &
                    ~ovf_prev_q;

  // Fault sources; set wins over a host write in the same cycle
  assign fault_set[7]              = 1'b0;
  assign fault_set[GSF_BIT_P1]     = act[2];                    // RQ10
  assign fault_set[GSF_BIT_P2]     = act[1];                    // RQ10
  assign fault_set[GSF_BIT_P3]     = act[0];                    // RQ10
  assign fault_set[GSF_BIT_WAKE]   = wake_exit_in &&
                                     stuck_bus_wake_enable_in;  // RQ11
  assign fault_set[GSF_BIT_ENERGY] = ovf_rise[2];               // RQ12
  assign fault_set[GSF_BIT_CHARGE] = ovf_rise[1];               // RQ12
  assign fault_set[GSF_BIT_TIME]   = ovf_rise[0];               // RQ12

  // Host writes replace the latch; bits then hold until written 0
  assign fault_d = (wr_fault ? reg_wdata_in : fault_q) | fault_set; // RQ17

  // Overflow alert per accumulator, gated by its enable
  assign ovf_alert   = |(ovf_rise & secondary_alert_enable_in); // RQ16
  assign alert_event = ovf_alert || other_alert_in;

  // Alert bit: hardware set or host write 1 sets; write 0 clears
  assign ctl_d[1] = alert_event ||
                    (wr_ctl ? reg_wdata_in[GSF_CTL_ALERT]
                            : ctl_q[1]); // RQ13
  assign ctl_d[0] = wr_ctl ? reg_wdata_in[GSF_CTL_PULL3] : ctl_q[0];

  // Read mux, registered so data leaves a flip-flop
  assign rdata_d =
    (reg_addr_in == GSF_OFS_PIN_CFG)   ? {cfg_q[7:1], 1'b0} :
    (reg_addr_in == GSF_OFS_STATE)     ? state_w :
    (reg_addr_in == GSF_OFS_FAULT)     ? fault_q :
    (reg_addr_in == GSF_OFS_PIN3_CTRL) ? {ctl_q, 6'h00} : 8'h00;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_q      <= GSF_RST_PIN_CFG;
      fault_q    <= GSF_RST_FAULT;
      ctl_q      <= GSF_RST_PIN3_CTRL[7:6];
      ovf_prev_q <= 3'h0;
      rdata_q    <= 8'h00;
    end else if (clk_en_in) begin
      if (wr_cfg) begin
        cfg_q <= {reg_wdata_in[7:1], 1'b0};
      end
      fault_q    <= fault_d;
      ctl_q      <= ctl_d;
      ovf_prev_q <= {energy_ovf_in, charge_ovf_in, time_ovf_in};
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
endmodule

// *** verification/gsf_pin_env.sv ***
// Outside world of the three pins: open-drain wires and external drivers
`timescale 1ns/100ps
module gsf_pin_env (
  input  wire logic [2:0] ext_in,
  input  wire logic [2:0] oe_n_in,
  output logic      [2:0] wire_out
);
  // A device pull-down always wins over the outside level
  assign wire_out = ext_in & oe_n_in;
endmodule

// *** verification/gsf_pins_assertions.sv ***
// Port assertions of the pin configuration and fault block
`timescale 1ns/100ps
module gsf_pins_chk (
  // Clock, reset and register access
  input wire logic       clk_in, reset_in, clk_en_in, reg_wr_in,
  input wire logic [7:0] reg_addr_in, reg_rdata_out,
  // Pins and core events
  input wire logic       second_pin_in, accumulate_gating_out, adc_busy_in,
  input wire logic       energy_ovf_in, charge_ovf_in, time_ovf_in,
  input wire logic       wake_exit_in, stuck_bus_wake_enable_in,
  input wire logic       other_alert_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire logic rd_st = clk_en_in && reg_addr_in == 8'h40;
  wire logic rd_ct = clk_en_in && reg_addr_in == 8'h42 && !reg_wr_in;
  sequence rd_fault;
    clk_en_in && reg_addr_in == 8'h41 && !reg_wr_in;
  endsequence
  AST_GATE: assert property (accumulate_gating_out |-> second_pin_in)
    else $error("gate high with low input");
  AST_BUSY: assert property (rd_st |=>
    reg_rdata_out[3] == $past(adc_busy_in)) else $error("busy bit");
  AST_OVF_STATE: assert property (rd_st |=>
    reg_rdata_out[2:0] == {$past(energy_ovf_in), $past(charge_ovf_in),
    $past(time_ovf_in)}) else $error("overflow state");
  AST_OVF_FAULT: assert property ($rose(energy_ovf_in) ##1 rd_fault
    |=> reg_rdata_out[2]) else $error("energy fault");
  AST_WAKE: assert property (wake_exit_in && stuck_bus_wake_enable_in
    ##1 rd_fault |=> reg_rdata_out[3]) else $error("wake fault");
  AST_HOLD: assert property (rd_fault [*2] |=>
    ($past(reg_rdata_out) & ~reg_rdata_out) == 8'h00) else $error("lost");
  AST_ALERT: assert property (other_alert_in ##1 rd_ct |=>
    reg_rdata_out[7]) else $error("alert bit");
  AST_CTRL_RSV: assert property (rd_ct |=> reg_rdata_out[5:0] == 6'h00)
    else $error("control low bits");
  AST_FREEZE: assert property (!clk_en_in |=> $stable(reg_rdata_out))
    else $error("read data moved while disabled");
endmodule
bind gsf_pins gsf_pins_chk chk_u (.*);

// *** verification/gsf_pins_tb.sv ***
// Self-checking bench of the pin configuration and fault block
`timescale 1ns/100ps
module gsf_pins_tb;
  logic        clk_in = 1'b0, reset_in = 1'b1, wr = 1'b0, wk = 1'b0;
  logic        wken = 1'b0, oth = 1'b0, busy = 1'b0, acc, hit, en = 1'b1;
  logic [2:0]  ovf = 3'h0, alen = 3'h0, ext = 3'h0, oe_n, pin, el, po;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdq, c, g;
  logic [31:0] rnd = 32'h68CFFF52;
  int          errors = 0, comparisons = 0;
  always #5 clk_in = ~clk_in;
  gsf_pins dut_u (.clk_in, .reset_in, .clk_en_in(en), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdq), .reg_hit_out(hit),
    .first_pin_in(pin[0]), .second_pin_in(pin[1]), .third_pin_in(pin[2]),
    .first_pin_out(po[0]), .first_pin_oe_n_out(oe_n[0]),
    .second_pin_out(po[1]),
    .second_pin_oe_n_out(oe_n[1]), .third_pin_out(po[2]),
    .third_pin_oe_n_out(oe_n[2]), .accumulate_gating_out(acc),
    .adc_busy_in(busy), .energy_ovf_in(ovf[2]), .charge_ovf_in(ovf[1]),
    .time_ovf_in(ovf[0]), .wake_exit_in(wk), .stuck_bus_wake_enable_in(wken),
    .secondary_alert_enable_in(alen), .other_alert_in(oth));
  gsf_pin_env env_u (.ext_in(ext), .oe_n_in(oe_n), .wire_out(pin));
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic act(logic [1:0] m, logic l);
    return m == 2'b11 ? l : m == 2'b10 && !l;
  endfunction
  // Enables wanted by a configuration and a control byte, low = pull
  function automatic logic [2:0] drv_n(logic [7:0] c, logic [7:0] g);
    return {c[3:2] == 2'b00 ? !g[7] : c[3:2] != 2'b01 || !g[6],
      !(c[5:4] == 2'b01 && c[1]), c[7:6] != 2'b00};
  endfunction
  task automatic t;
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(logic [7:0] a, logic [7:0] d);
    {addr, wd, wr} = {a, d, 1'b1};
    t;
    wr = 1'b0;
    t;
  endtask
  task automatic r(logic [7:0] a, logic [7:0] e, string n);
    addr = a;
    t;
    chk(n, rdq, e);
    chk("hit", hit, a inside {8'h33, 8'h40, 8'h41, 8'h42});
  endtask
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_in);
    errors++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk_in);
    #1 reset_in = 1'b0;
    r(8'h41, 8'h80, "fault reset");
    for (int i = 0; i < 40; i++) begin
      rnd = nx(rnd);
      c = {i < 4 ? {3{i[1:0]}} : rnd[5:0], rnd[6], 1'b0};
      g = {rnd[8:7], 6'h00};
      w(8'h33, c);
      w(8'h42, g);
      {ext, busy, ovf} = rnd[15:9];
      el = ext & drv_n(c, g);
      r(8'h40, {1'b0, act(c[7:6], el[0]), c[5:4] == 2'b00 ? el[1] :
        act(c[5:4], el[1]), act(c[3:2], el[2]), busy, ovf}, "state");
      chk("drive", oe_n, drv_n(c, g));
      chk("gate", acc, c[5:4] == 2'b00 && el[1]);
      chk("pin level", po, 8'h00);
      r(8'h42, g, "control");
    end
    $display("mode test done");
    {ext, busy, ovf} = 7'h00;
    w(8'h33, 8'hFC);
    w(8'h41, 8'h00);
    {ext, wk} = 4'hF;
    t;
    {ext, wk} = 4'h0;
    r(8'h41, 8'h70, "pin faults");
    {wken, wk, ovf} = 5'h1F;
    t;
    wk = 1'b0;
    r(8'h41, 8'h7F, "event faults");
    r(8'h41, 8'h7F, "held faults");
    $display("fault test done");
    ovf = 3'h0;
    w(8'h33, 8'hF0);
    w(8'h42, 8'h00);
    {alen, ovf} = 6'h2A;
    t;
    r(8'h42, 8'h00, "masked alert");
    {alen, ovf} = 6'h10;
    t;
    ovf = 3'h2;
    t;
    r(8'h42, 8'h80, "overflow alert");
    chk("alert pin", oe_n[2], 8'h00);
    w(8'h42, 8'h00);
    chk("alert release", oe_n[2], 8'h01);
    oth = 1'b1;
    t;
    oth = 1'b0;
    r(8'h42, 8'h80, "other alert");
    $display("alert test done");
    en = 1'b0;
    w(8'h41, 8'h00);
    en = 1'b1;
    r(8'h41, 8'h7F, "frozen fault");
    r(8'h43, 8'h00, "unmapped");
    $display("enable test done");
    complete_run;
  end
endmodule
